/* src/bbf_pkg.sv */
// Constants, field layouts and types for the backlight brightness and boost frequency control.
// Assumes a 20 MHz system clock. Register writes arrive already decoded from the serial bus.
package bbf_pkg;
    // Register offsets
    localparam logic [7:0] BBF_ADDR_BRIGHT_CTRL = 8'h11;
    localparam logic [7:0] BBF_ADDR_BOOST = 8'h13;
    localparam logic [7:0] BBF_ADDR_AUTO_HI = 8'h15;
    localparam logic [7:0] BBF_ADDR_AUTO_LO = 8'h16;
    localparam logic [7:0] BBF_ADDR_OVR = 8'h17;
    localparam logic [7:0] BBF_ADDR_BRIGHT_LSB = 8'h18;
    localparam logic [7:0] BBF_ADDR_BRIGHT_MSB = 8'h19;

    // Field positions
    localparam int BBF_POL_BIT = 0;
    localparam int BBF_MODE_LO = 1;
    localparam int BBF_RAMP_LO = 3;
    localparam int BBF_MININD_BIT = 4;
    localparam int BBF_FSEL_BIT = 5;
    localparam int BBF_SHIFT_BIT = 6;

    // Reset values
    localparam logic [7:0] BBF_RST_BYTE = 8'h00;
    localparam logic [2:0] BBF_RST_LSB = 3'h0;
    localparam logic [10:0] BBF_RST_CODE = 11'h000;

    // Timing
    localparam int BBF_CLK_HZ = 20_000_000;
    localparam int BBF_OVR_MAX_US = 50;
    localparam int BBF_OVR_MAX_CYC = BBF_OVR_MAX_US * (BBF_CLK_HZ / 1_000_000);
    localparam logic [11:0] BBF_RAMP_BASE_CYC = 12'h014;

    typedef enum logic [1:0] {
        BBF_MODE_BUS = 2'h0,
        BBF_MODE_PWM = 2'h1,
        BBF_MODE_MUL_RAMP = 2'h2,
        BBF_MODE_RAMP_MUL = 2'h3
    } bbf_mode_t;

    typedef enum logic [1:0] {
        BBF_FREQ_250K = 2'h0,
        BBF_FREQ_500K = 2'h1,
        BBF_FREQ_1M = 2'h2
    } bbf_freq_t;

    // Code times duty, 2047 counts as full scale so full duty is exact
    function automatic logic [10:0] bbf_mul_code(input logic [10:0] code, input logic [10:0] duty);
        logic [22:0] prod;
        prod = 23'(code) * 23'({1'b0, duty} + 12'h001);
        return prod[21:11];
    endfunction

    function automatic logic [11:0] bbf_ramp_interval(input logic [2:0] rate);
        return 12'(BBF_RAMP_BASE_CYC << rate);
    endfunction
endpackage

/* src/bbf_ramp_if.sv */
// Link between the brightness control and its ramper.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/100ps
interface bbf_ramp_if;
    logic [10:0] target;
    logic [2:0] rate;
    logic [10:0] level;
    modport ctrl (output target, output rate, input level);
    modport ramp (input target, input rate, output level);
endinterface

/* src/bbf_ramper.sv */
// Ramper: walks its level one code per programmed interval toward the target; rate 0 jumps straight to it.
// Assumes an active-low reset, cleared at once, released in step with clk_in by the parent.
`timescale 1ns/100ps
module bbf_ramper
    import bbf_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Control side
    bbf_ramp_if.ramp rif
);
    typedef enum logic [1:0] {
        RMP_IDLE = 2'b01,
        RMP_STEP = 2'b10
    } bbf_rmp_state_t;

    bbf_rmp_state_t state_r;
    bbf_rmp_state_t state_nxt;
    logic [10:0] level_r;
    logic [10:0] level_nxt;
    logic [11:0] cnt_r;
    logic [11:0] cnt_nxt;

    wire logic differ = (level_r != rif.target);
    wire logic go_up = (rif.target > level_r);
    wire logic no_ramp = (rif.rate == 3'h0);
    wire logic tick = (cnt_r >= bbf_ramp_interval(rif.rate) - 12'h001);

    // Step of one code per interval, so duration scales with distance; rate 0 jumps at once
    always_comb begin
        state_nxt = state_r;
        level_nxt = level_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            RMP_IDLE: begin
                cnt_nxt = 12'h000;
                if (differ && no_ramp) begin
                    level_nxt = rif.target;
                end else if (differ) begin
                    state_nxt = RMP_STEP;
                end
            end
            RMP_STEP: begin
                if (!differ) begin
                    state_nxt = RMP_IDLE;
                    cnt_nxt = 12'h000;
                end else if (no_ramp) begin
                    level_nxt = rif.target;
                    state_nxt = RMP_IDLE;
                end else if (tick) begin
                    cnt_nxt = 12'h000;
                    level_nxt = go_up ? level_r + 11'h001 : level_r - 11'h001;
                end else begin
                    cnt_nxt = cnt_r + 12'h001;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= RMP_IDLE;
            level_r <= BBF_RST_CODE;
            cnt_r <= 12'h000;
        end else begin
            state_r <= state_nxt;
            level_r <= level_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign rif.level = level_r;

    property p_ramp_single_step;
        @(posedge clk_in) disable iff (!rst_n_in)
        (rif.rate != 3'h0) && $stable(rif.rate) |=>
            (level_r == $past(level_r)) || (level_r == $past(level_r) + 11'h001) ||
            (level_r == $past(level_r) - 11'h001);
    endproperty
    a_ramp_single_step: assert property (p_ramp_single_step) else $error("ramper moved more than one code");
endmodule

/* src/bbf_ctrl_top.sv */
// Backlight brightness code and boost frequency control, top level.
// Assumes register writes and reads arrive decoded, and a measured duty code synchronous to clk_in.
`timescale 1ns/100ps
module bbf_ctrl_top
    import bbf_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Register access
    input wire logic reg_wr_en_in,
    input wire logic [7:0] reg_wr_addr_in,
    input wire logic [7:0] reg_wr_data_in,
    input wire logic [7:0] reg_rd_addr_in,
    output logic [7:0] reg_rd_data_out,
    // Brightness sources
    input wire logic [10:0] pwm_duty_in,
    input wire logic dimming_override_input_in,
    // Mapper and boost controls
    output logic [10:0] led_code_out,
    output logic [1:0] boost_freq_out,
    output logic freq_shift_out,
    output logic dmax_limit_out,
    output logic min_inductor_out
);
    logic rst_sync1_r;
    logic rst_n_r;

    // Release only; assertion is immediate through the async clear
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_sync1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_sync1_r <= 1'b1;
            rst_n_r <= rst_sync1_r;
        end
    end

    logic [7:0] bright_ctrl_r;
    logic [7:0] boost_r;
    logic [7:0] auto_hi_r;
    logic [7:0] auto_lo_r;
    logic [7:0] ovr_msb_r;
    logic [2:0] bright_lsb_r;
    logic [7:0] bright_msb_r;
    logic [10:0] bright_code_r;

    wire logic wr_ctrl = reg_wr_en_in && (reg_wr_addr_in == BBF_ADDR_BRIGHT_CTRL);
    wire logic wr_boost = reg_wr_en_in && (reg_wr_addr_in == BBF_ADDR_BOOST);
    wire logic wr_hi = reg_wr_en_in && (reg_wr_addr_in == BBF_ADDR_AUTO_HI);
    wire logic wr_lo = reg_wr_en_in && (reg_wr_addr_in == BBF_ADDR_AUTO_LO);
    wire logic wr_ovr = reg_wr_en_in && (reg_wr_addr_in == BBF_ADDR_OVR);
    wire logic wr_lsb = reg_wr_en_in && (reg_wr_addr_in == BBF_ADDR_BRIGHT_LSB);
    wire logic wr_msb = reg_wr_en_in && (reg_wr_addr_in == BBF_ADDR_BRIGHT_MSB);

    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            bright_ctrl_r <= BBF_RST_BYTE;
            boost_r <= BBF_RST_BYTE;
            auto_hi_r <= BBF_RST_BYTE;
            auto_lo_r <= BBF_RST_BYTE;
            ovr_msb_r <= BBF_RST_BYTE;
            bright_lsb_r <= BBF_RST_LSB;
            bright_msb_r <= BBF_RST_BYTE;
            bright_code_r <= BBF_RST_CODE;
        end else begin
            if (wr_ctrl) bright_ctrl_r <= reg_wr_data_in;
            if (wr_boost) boost_r <= reg_wr_data_in;
            if (wr_hi) auto_hi_r <= reg_wr_data_in;
            if (wr_lo) auto_lo_r <= reg_wr_data_in;
            if (wr_ovr) ovr_msb_r <= reg_wr_data_in;
            if (wr_lsb) bright_lsb_r <= reg_wr_data_in[2:0];
            if (wr_msb) begin
                bright_msb_r <= reg_wr_data_in;
                bright_code_r <= {reg_wr_data_in, bright_lsb_r};
            end
        end
    end

    // Read mux
    logic [7:0] rd_nxt;
    always_comb begin
        unique case (reg_rd_addr_in)
            BBF_ADDR_BRIGHT_CTRL: rd_nxt = bright_ctrl_r;
            BBF_ADDR_BOOST: rd_nxt = boost_r;
            BBF_ADDR_AUTO_HI: rd_nxt = auto_hi_r;
            BBF_ADDR_AUTO_LO: rd_nxt = auto_lo_r;
            BBF_ADDR_OVR: rd_nxt = ovr_msb_r;
            BBF_ADDR_BRIGHT_LSB: rd_nxt = {5'h00, bright_lsb_r};
            BBF_ADDR_BRIGHT_MSB: rd_nxt = bright_msb_r;
            default: rd_nxt = 8'h00;
        endcase
    end

    // Brightness path
    bbf_mode_t mode;
    assign mode = bbf_mode_t'(bright_ctrl_r[BBF_MODE_LO +: 2]);
    wire logic [2:0] ramp_rate = bright_ctrl_r[BBF_RAMP_LO +: 3];

    bbf_ramp_if rif();
    bbf_ramper u_ramper (
        .clk_in(clk_in),
        .rst_n_in(rst_n_r),
        .rif(rif.ramp)
    );

    logic [10:0] ramp_in;
    always_comb begin
        unique case (mode)
            BBF_MODE_BUS: ramp_in = bright_code_r;
            BBF_MODE_PWM: ramp_in = pwm_duty_in;
            BBF_MODE_MUL_RAMP: ramp_in = bbf_mul_code(bright_code_r, pwm_duty_in);
            BBF_MODE_RAMP_MUL: ramp_in = bright_code_r;
        endcase
    end
    assign rif.target = ramp_in;
    assign rif.rate = ramp_rate;

    // In BBF_MODE_RAMP_MUL duty is applied after the ramper so duty steps are immediate
    wire logic [10:0] nominal = (mode == BBF_MODE_RAMP_MUL) ?
        bbf_mul_code(rif.level, pwm_duty_in) : rif.level;

    // Override bypasses the ramper, reaching target in one cycle when its code is below nominal
    wire logic ovr_active = dimming_override_input_in ^ bright_ctrl_r[BBF_POL_BIT];
    wire logic [10:0] ovr_code = {ovr_msb_r, 3'h0};
    wire logic ovr_lowers = ovr_active && (ovr_code < nominal);
    // Ramper keeps tracking underneath, so release restores the prior target
    wire logic [10:0] led_nxt = ovr_lowers ? ovr_code : nominal;

    // Boost frequency
    wire logic auto_en = (auto_hi_r != 8'h00) || (auto_lo_r != 8'h00);
    wire bbf_freq_t prog_freq = boost_r[BBF_FSEL_BIT] ? BBF_FREQ_1M : BBF_FREQ_500K;
    wire logic below_lo = bright_msb_r < auto_lo_r;
    wire logic at_hi = bright_msb_r >= auto_hi_r;
    // Equal to low threshold lands in the middle band
    wire bbf_freq_t auto_freq = below_lo ? BBF_FREQ_250K :
        (at_hi ? BBF_FREQ_1M : BBF_FREQ_500K);
    wire bbf_freq_t freq_nxt = auto_en ? auto_freq : prog_freq;

    always_ff @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            reg_rd_data_out <= 8'h00;
            led_code_out <= BBF_RST_CODE;
            boost_freq_out <= BBF_FREQ_500K;
            freq_shift_out <= 1'b0;
            dmax_limit_out <= 1'b0;
            min_inductor_out <= 1'b0;
        end else begin
            reg_rd_data_out <= rd_nxt;
            led_code_out <= led_nxt;
            boost_freq_out <= freq_nxt;
            freq_shift_out <= boost_r[BBF_SHIFT_BIT];
            dmax_limit_out <= (freq_nxt == BBF_FREQ_250K);
            min_inductor_out <= boost_r[BBF_MININD_BIT];
        end
    end

    property p_code_on_msb;
        @(posedge clk_in) disable iff (!rst_n_r)
        $changed(bright_code_r) |-> $past(wr_msb);
    endproperty
    a_code_on_msb: assert property (p_code_on_msb) else $error("bus code changed without MSB write");

    property p_never_raise;
        @(posedge clk_in) disable iff (!rst_n_r)
        ##1 led_code_out <= $past(nominal);
    endproperty
    a_never_raise: assert property (p_never_raise) else $error("override raised the current");

    property p_ovr_fast;
        @(posedge clk_in) disable iff (!rst_n_r)
        ovr_active && (ovr_code < nominal) |=> led_code_out == $past(ovr_code);
    endproperty
    a_ovr_fast: assert property (p_ovr_fast) else $error("override target not applied");

    property p_ovr_release;
        @(posedge clk_in) disable iff (!rst_n_r)
        $fell(ovr_active) |-> ##1 led_code_out == $past(nominal);
    endproperty
    a_ovr_release: assert property (p_ovr_release) else $error("release did not restore target");

    property p_prog_freq;
        @(posedge clk_in) disable iff (!rst_n_r)
        !auto_en |=> boost_freq_out == ($past(boost_r[BBF_FSEL_BIT]) ? BBF_FREQ_1M : BBF_FREQ_500K);
    endproperty
    a_prog_freq: assert property (p_prog_freq) else $error("programmed frequency not used");

    property p_auto_low;
        @(posedge clk_in) disable iff (!rst_n_r)
        auto_en && (bright_msb_r < auto_lo_r) |=> boost_freq_out == BBF_FREQ_250K;
    endproperty
    a_auto_low: assert property (p_auto_low) else $error("low band not 250 kHz");

    property p_auto_mid;
        @(posedge clk_in) disable iff (!rst_n_r)
        auto_en && (bright_msb_r >= auto_lo_r) && (bright_msb_r < auto_hi_r) |=> boost_freq_out == BBF_FREQ_500K;
    endproperty
    a_auto_mid: assert property (p_auto_mid) else $error("middle band not 500 kHz");

    property p_auto_high;
        @(posedge clk_in) disable iff (!rst_n_r)
        auto_en && (bright_msb_r >= auto_lo_r) && (bright_msb_r >= auto_hi_r) |=> boost_freq_out == BBF_FREQ_1M;
    endproperty
    a_auto_high: assert property (p_auto_high) else $error("high band not 1 MHz");

    property p_low_freq_dmax;
        @(posedge clk_in) disable iff (!rst_n_r)
        ##1 (dmax_limit_out == (boost_freq_out == BBF_FREQ_250K)) && ((boost_freq_out == BBF_FREQ_250K) -> $past(auto_en));
    endproperty
    a_low_freq_dmax: assert property (p_low_freq_dmax) else $error("250 kHz outside auto or unlimited");

    property p_shift;
        @(posedge clk_in) disable iff (!rst_n_r)
        wr_boost ##1 !wr_boost |=> freq_shift_out == $past(reg_wr_data_in[BBF_SHIFT_BIT], 2);
    endproperty
    a_shift: assert property (p_shift) else $error("shift bit not followed");
endmodule

/* dv/bbf_host_model.sv */
// Host and PWM source model: decoded register writes and reads, duty code, override pin.
// Assumes the control block samples its inputs on the rising edge of clk_in.
`timescale 1ns/100ps
module bbf_host_model
    import bbf_pkg::*;
#(
    parameter bit IND_22UH = 1'b1
)
(
    // Clock
    input wire logic clk_in,
    // Register access
    output logic wr_en_out,
    output logic [7:0] wr_addr_out,
    output logic [7:0] wr_data_out,
    output logic [7:0] rd_addr_out,
    input wire logic [7:0] rd_data_in,
    // Brightness sources
    output logic [10:0] duty_out,
    output logic ovr_pin_out
);
    initial begin
        wr_en_out = 1'b0;
        wr_addr_out = 8'h00;
        wr_data_out = 8'h00;
        rd_addr_out = 8'h00;
        duty_out = 11'h000;
        ovr_pin_out = 1'b0;
    end

    // Bus lines show inverted junk once the strobe drops
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        wr_en_out = 1'b1;
        wr_addr_out = a;
        wr_data_out = d;
        @(negedge clk_in);
        wr_en_out = 1'b0;
        wr_addr_out = ~a;
        wr_data_out = ~d;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        rd_addr_out = a;
        @(negedge clk_in);
        d = rd_data_in;
    endtask

    // Inductor select follows the fitted part
    task automatic write_boost(input logic f1m, input logic shift);
        write_reg(BBF_ADDR_BOOST, {1'b0, shift, f1m, IND_22UH, 4'h0});
    endtask

    task automatic set_src(input logic [10:0] d, input logic pin);
        @(negedge clk_in);
        duty_out = d;
        ovr_pin_out = pin;
    endtask
endmodule

/* dv/tb.sv */
// Self-checking bench for the brightness and boost frequency control.
// Assumes the host model drives every design input except clock and reset at the falling edge.
`timescale 1ns/100ps
module tb
    import bbf_pkg::*;
;
    logic clk_in;
    logic reset_n_in;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic [10:0] duty;
    logic ovr_pin;
    logic [10:0] led;
    logic [1:0] freq;
    logic shift;
    logic dmax;
    logic min_ind;
    int bad_count;
    int n_checks;

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    bbf_ctrl_top bbf_ctrl_top_inst (.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_wr_en_in(wr_en),
        .reg_wr_addr_in(wr_addr), .reg_wr_data_in(wr_data), .reg_rd_addr_in(rd_addr),
        .reg_rd_data_out(rd_data), .pwm_duty_in(duty), .dimming_override_input_in(ovr_pin),
        .led_code_out(led), .boost_freq_out(freq), .freq_shift_out(shift), .dmax_limit_out(dmax),
        .min_inductor_out(min_ind));

    bbf_host_model bbf_host_model_inst (.clk_in(clk_in), .wr_en_out(wr_en), .wr_addr_out(wr_addr),
        .wr_data_out(wr_data), .rd_addr_out(rd_addr), .rd_data_in(rd_data), .duty_out(duty),
        .ovr_pin_out(ovr_pin));

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded wait; running out ends the run
    task automatic wait_led(input logic [10:0] exp, input int limit);
        for (int i = 0; i < limit && led !== exp; i++) begin
            @(negedge clk_in);
        end
        check(16'(led), 16'(exp));
        if (led !== exp) begin
            final_report();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bbf_host_model_inst.write_reg(a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        bbf_host_model_inst.read_reg(a, v);
        check(16'(v), 16'(exp));
    endtask

    task automatic set_ctrl(input logic [2:0] rate, input logic [1:0] mode, input logic pol);
        wr(BBF_ADDR_BRIGHT_CTRL, {2'h0, rate, mode, pol});
    endtask

    // Independent model of code times duty, full duty exact
    function automatic logic [10:0] scaled(input logic [10:0] c, input logic [10:0] d);
        logic [22:0] p;
        p = 23'(c) * (23'(d) + 23'h1);
        return p[21:11];
    endfunction

    task automatic t_reset();
        logic [7:0] addrs [8] = '{8'h11, 8'h13, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h20};
        check(16'(led), 16'h0000);
        check(16'(freq), 16'(BBF_FREQ_500K));
        foreach (addrs[i]) begin
            rd_chk(addrs[i], 8'h00);
        end
    endtask

    task automatic t_bus_code();
        set_ctrl(3'h0, 2'h0, 1'b0);
        wr(BBF_ADDR_BRIGHT_LSB, 8'hff);
        rd_chk(BBF_ADDR_BRIGHT_LSB, 8'h07);
        check(16'(led), 16'h0000);
        wr(BBF_ADDR_BRIGHT_MSB, 8'hab);
        wait_led(11'h55f, 4);
    endtask

    task automatic t_modes();
        logic [10:0] e [4];
        bbf_host_model_inst.set_src(11'h3ff, 1'b0);
        e = '{11'h55f, 11'h3ff, scaled(11'h55f, 11'h3ff), scaled(11'h55f, 11'h3ff)};
        for (int m = 0; m < 4; m++) begin
            set_ctrl(3'h0, 2'(m), 1'b0);
            // Let the previous mode's code drain before judging
            repeat (2) @(negedge clk_in);
            wait_led(e[m], 6);
        end
    endtask

    task automatic t_ramp_mul();
        set_ctrl(3'h1, 2'h3, 1'b0);
        bbf_host_model_inst.set_src(11'h7ff, 1'b0);
        wait_led(11'h55f, 3);
        set_ctrl(3'h1, 2'h2, 1'b0);
        bbf_host_model_inst.set_src(11'h3ff, 1'b0);
        repeat (20) @(negedge clk_in);
        check(16'(led), 16'h055f);
        wait_led(11'h55e, 60);
        repeat (30) @(negedge clk_in);
        check(16'(led), 16'h055e);
        repeat (20) @(negedge clk_in);
        check(16'(led), 16'h055d);
        set_ctrl(3'h0, 2'h0, 1'b0);
    endtask

    task automatic t_freq();
        logic [7:0] msb [5] = '{8'h3f, 8'h40, 8'h7f, 8'h80, 8'hff};
        logic [1:0] ef [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
        wr(BBF_ADDR_BOOST, 8'h00);
        repeat (2) @(negedge clk_in);
        check(16'(min_ind), 16'h0);
        for (int k = 0; k < 4; k++) begin
            bbf_host_model_inst.write_boost(k[0], k[1]);
            repeat (2) @(negedge clk_in);
            check(16'(freq), k[0] ? 16'h2 : 16'h1);
            check(16'(shift), 16'(k[1]));
            check(16'(min_ind), 16'h1);
            check(16'(dmax), 16'h0);
        end
        wr(BBF_ADDR_AUTO_HI, 8'h80);
        wr(BBF_ADDR_AUTO_LO, 8'h40);
        rd_chk(BBF_ADDR_AUTO_HI, 8'h80);
        foreach (msb[i]) begin
            wr(BBF_ADDR_BRIGHT_MSB, msb[i]);
            repeat (2) @(negedge clk_in);
            check(16'(freq), 16'(ef[i]));
            check(16'(dmax), 16'(ef[i] == 2'h0));
        end
        wr(BBF_ADDR_AUTO_LO, 8'h00);
        wr(BBF_ADDR_BRIGHT_MSB, 8'h3f);
        repeat (2) @(negedge clk_in);
        check(16'(freq), 16'h1);
        wr(BBF_ADDR_AUTO_HI, 8'h00);
        repeat (2) @(negedge clk_in);
        check(16'(freq), 16'h2);
    endtask

    task automatic t_override();
        wr(BBF_ADDR_BRIGHT_LSB, 8'h05);
        wr(BBF_ADDR_BRIGHT_MSB, 8'h80);
        wr(BBF_ADDR_OVR, 8'h20);
        wait_led(11'h405, 4);
        bbf_host_model_inst.set_src(11'h3ff, 1'b1);
        wait_led(11'h100, BBF_OVR_MAX_CYC);
        bbf_host_model_inst.set_src(11'h3ff, 1'b0);
        wait_led(11'h405, 4);
        wr(BBF_ADDR_OVR, 8'h81);
        bbf_host_model_inst.set_src(11'h3ff, 1'b1);
        repeat (4) @(negedge clk_in);
        check(16'(led), 16'h0405);
        wr(BBF_ADDR_OVR, 8'h20);
        set_ctrl(3'h0, 2'h0, 1'b1);
        wait_led(11'h405, 4);
        bbf_host_model_inst.set_src(11'h3ff, 1'b0);
        wait_led(11'h100, 4);
    endtask

    initial begin
        bad_count = 0;
        n_checks = 0;
        reset_n_in = 1'b0;
        repeat (16) @(negedge clk_in);
        reset_n_in = 1'b1;
        repeat (3) @(negedge clk_in);
        t_reset();
        t_bus_code();
        t_modes();
        t_ramp_mul();
        t_freq();
        t_override();
        final_report();
    end
endmodule
